// ### ecac_host.sv
// CPU end: APB slave taking read and write orders, sequenced onto the core I/O link.
// Assumes APB on the same core clock; pready is always high, answers take no wait state.
`include "ecac_cfg.svh"
`default_nettype none

module ecac_host #(
  parameter int AW = 11
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Core link
  ecac_if.cpu LINK
);

  typedef struct packed {
    ecac_pkg::ecac_hstate_t st;
    logic is_wr;
    logic [2:0] step;
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic gie;
    logic spm;
    logic rie;
    logic [5:0] io_addr;
    logic [7:0] io_wdata;
    logic io_we;
    logic io_re;
  } ecac_host_state_t;

  ecac_host_state_t s_r;
  ecac_host_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Link step table: offset, data and last flag for each write of a sequence
  function automatic logic [14:0] ecac_step(input ecac_host_state_t s);
    logic [15:0] wide;
    logic [7:0] ctl;
    wide = 16'h0000;
    wide[AW-1:0] = s.addr;
    ctl = 8'h00;
    ctl[`ECAC_CTL_RIE] = s.rie;
    unique case (s.step)
      3'h0: ecac_step = {`ECAC_IO_ADDR_LO, wide[7:0], 1'b0};
      3'h1: ecac_step = {`ECAC_IO_ADDR_HI, wide[15:8], 1'b0};
      3'h2:
      begin
        ctl[`ECAC_CTL_RSTB] = 1'b1;
        ecac_step = s.is_wr ? {`ECAC_IO_DATA, s.wdata, 1'b0} : {`ECAC_IO_CONTROL, ctl, 1'b1};
      end
      3'h3:
      begin
        ctl[`ECAC_CTL_ARM] = 1'b1;
        ecac_step = {`ECAC_IO_CONTROL, ctl, 1'b0};
      end
      default:
      begin
        ctl[`ECAC_CTL_ARM] = 1'b1;
        ctl[`ECAC_CTL_WSTB] = 1'b1;
        ecac_step = {`ECAC_IO_CONTROL, ctl, 1'b1};
      end
    endcase
  endfunction : ecac_step

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic: APB registers and the link sequencer
  always_comb
  begin
    logic [14:0] stp;
    logic acc;
    acc = I_PSEL && I_PENABLE;
    stp = ecac_step(s_r);
    s_nxt = s_r;
    s_nxt.io_we = 1'b0;
    s_nxt.io_re = 1'b0;

    // APB writes; orders arriving while busy are dropped
    if (acc && I_PWRITE)
    begin
      unique case (I_PADDR)
        `ECAC_APB_CMD:
          if (s_r.st == ecac_pkg::H_IDLE && (I_PWDATA[`ECAC_CMD_READ] || I_PWDATA[`ECAC_CMD_WRITE]))
          begin
            s_nxt.st = ecac_pkg::H_POLL;
            s_nxt.is_wr = I_PWDATA[`ECAC_CMD_WRITE];
            s_nxt.step = 3'h0;
          end
        `ECAC_APB_ADDR: s_nxt.addr = I_PWDATA[AW-1:0];
        `ECAC_APB_WDATA: s_nxt.wdata = I_PWDATA[7:0];
        `ECAC_APB_CONFIG:
        begin
          s_nxt.gie = I_PWDATA[`ECAC_CFG_GIE];
          s_nxt.spm = I_PWDATA[`ECAC_CFG_SPM];
          s_nxt.rie = I_PWDATA[`ECAC_CFG_RIE];
        end
        default: s_nxt.st = s_r.st;
      endcase
    end

    // Sequencer; nothing is issued while the core is halted
    unique case (s_r.st)
      ecac_pkg::H_IDLE: s_nxt.st = s_nxt.st;
      ecac_pkg::H_POLL:
        if (!LINK.cpu_halt)
        begin
          s_nxt.io_addr = `ECAC_IO_CONTROL;
          s_nxt.io_re = 1'b1;
          s_nxt.st = ecac_pkg::H_POLL_WT;
        end
      ecac_pkg::H_POLL_WT:
        // Wait for the previous write, and for flash self-programming before a write
        if (s_r.io_re)
          s_nxt.st = s_r.st;
        else if (LINK.io_rdata[`ECAC_CTL_WSTB] || (s_r.is_wr && s_r.spm))
          s_nxt.st = ecac_pkg::H_POLL;
        else
          s_nxt.st = ecac_pkg::H_ACCESS;
      ecac_pkg::H_ACCESS:
        if (!LINK.cpu_halt)
        begin
          {s_nxt.io_addr, s_nxt.io_wdata} = stp[14:1];
          s_nxt.io_we = 1'b1;
          s_nxt.step = s_r.step + 3'h1;
          if (stp[0])
            s_nxt.st = ecac_pkg::H_SETTLE;
        end
      ecac_pkg::H_SETTLE:
        // One cycle so that a halt raised by the last write is seen
        s_nxt.st = s_r.is_wr ? ecac_pkg::H_IDLE : ecac_pkg::H_RD_REQ;
      ecac_pkg::H_RD_REQ:
        if (!LINK.cpu_halt)
        begin
          s_nxt.io_addr = `ECAC_IO_DATA;
          s_nxt.io_re = 1'b1;
          s_nxt.st = ecac_pkg::H_RD_WT;
        end
      ecac_pkg::H_RD_WT:
        if (!s_r.io_re)
        begin
          s_nxt.rdata = LINK.io_rdata;
          s_nxt.st = ecac_pkg::H_IDLE;
        end
      default: s_nxt.st = ecac_pkg::H_IDLE;
    endcase

    if (!I_RST_N)
    begin
      s_nxt = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge I_CORE_CLK)
  begin
    s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB read mux and answers
  always_comb
  begin
    O_PRDATA = 32'h0000_0000;
    O_PSLVERR = 1'b0;
    unique case (I_PADDR)
      `ECAC_APB_CMD: O_PRDATA = 32'h0000_0000;
      `ECAC_APB_ADDR: O_PRDATA[AW-1:0] = s_r.addr;
      `ECAC_APB_WDATA: O_PRDATA[7:0] = s_r.wdata;
      `ECAC_APB_RDATA: O_PRDATA[7:0] = s_r.rdata;
      `ECAC_APB_STATUS:
      begin
        O_PRDATA[`ECAC_ST_BUSY] = (s_r.st != ecac_pkg::H_IDLE);
        O_PRDATA[`ECAC_ST_IRQ] = LINK.ready_irq;
        O_PRDATA[`ECAC_ST_WACT] = LINK.io_rdata[`ECAC_CTL_WSTB];
      end
      `ECAC_APB_CONFIG:
      begin
        O_PRDATA[`ECAC_CFG_GIE] = s_r.gie;
        O_PRDATA[`ECAC_CFG_SPM] = s_r.spm;
        O_PRDATA[`ECAC_CFG_RIE] = s_r.rie;
      end
      default: O_PSLVERR = I_PSEL && I_PENABLE;
    endcase
  end

  // Link outputs; interrupts are held off while a sequence runs
  assign O_PREADY = 1'b1;
  assign LINK.io_addr = s_r.io_addr;
  assign LINK.io_wdata = s_r.io_wdata;
  assign LINK.io_we = s_r.io_we;
  assign LINK.io_re = s_r.io_re;
  assign LINK.global_irq_en = s_r.gie && (s_r.st == ecac_pkg::H_IDLE);
  assign LINK.self_program_busy = s_r.spm;

endmodule : ecac_host

`default_nettype wire

// ### ecac_cfg.svh
// Constants for the data EEPROM CPU access block: I/O offsets, bit positions, timing.
// Assumes a 50 MHz core clock and a 1 MHz calibrated oscillator rate for write timing.
`ifndef ECAC_CFG_SVH
`define ECAC_CFG_SVH

// I/O register offsets on the core side
`define ECAC_IO_CONTROL 6'h1c
`define ECAC_IO_DATA 6'h1d
`define ECAC_IO_ADDR_LO 6'h1e
`define ECAC_IO_ADDR_HI 6'h1f

// Control register bit positions
`define ECAC_CTL_RIE 3
`define ECAC_CTL_ARM 2
`define ECAC_CTL_WSTB 1
`define ECAC_CTL_RSTB 0

// Timing: arm window and halt lengths in core cycles
`define ECAC_ARM_WINDOW 3'h4
`define ECAC_WRITE_HALT 3'h2
`define ECAC_READ_HALT 3'h4

// Write time: oscillator cycles at the oscillator rate, converted to core cycles
`define ECAC_WRITE_OSC_CYCLES 8448
`define ECAC_OSC_KHZ 1000
`define ECAC_CLK_KHZ 50000
`define ECAC_WRITE_CLKS (`ECAC_WRITE_OSC_CYCLES * (`ECAC_CLK_KHZ / `ECAC_OSC_KHZ))

// Controller APB register offsets
`define ECAC_APB_CMD 12'h000
`define ECAC_APB_ADDR 12'h004
`define ECAC_APB_WDATA 12'h008
`define ECAC_APB_RDATA 12'h00c
`define ECAC_APB_STATUS 12'h010
`define ECAC_APB_CONFIG 12'h014

// Controller register bit positions
`define ECAC_CMD_READ 0
`define ECAC_CMD_WRITE 1
`define ECAC_ST_BUSY 0
`define ECAC_ST_IRQ 1
`define ECAC_ST_WACT 2
`define ECAC_CFG_GIE 0
`define ECAC_CFG_SPM 1
`define ECAC_CFG_RIE 2

`endif

// ### ecac_pkg.sv
// Types for the CPU end of the data EEPROM CPU access block.
// Assumes ecac_cfg.svh for all numeric constants.
`default_nettype none

package ecac_pkg;

  // Controller sequencer states
  typedef enum logic [2:0] {
    H_IDLE,
    H_POLL,
    H_POLL_WT,
    H_ACCESS,
    H_SETTLE,
    H_RD_REQ,
    H_RD_WT
  } ecac_hstate_t;

endpackage : ecac_pkg

`default_nettype wire

// ### ecac_if.sv
// Core-side I/O link between the CPU end and the EEPROM access device.
// Assumes both ends run on the same core clock; no clocking block here.
`default_nettype none

interface ecac_if;
  logic [5:0] io_addr;
  logic [7:0] io_wdata;
  logic io_we;
  logic io_re;
  logic [7:0] io_rdata;
  logic cpu_halt;
  logic ready_irq;
  logic global_irq_en;
  logic self_program_busy;

  // Device end
  modport dev (
    input io_addr, io_wdata, io_we, io_re, global_irq_en, self_program_busy,
    output io_rdata, cpu_halt, ready_irq
  );

  // CPU end
  modport cpu (
    output io_addr, io_wdata, io_we, io_re, global_irq_en, self_program_busy,
    input io_rdata, cpu_halt, ready_irq
  );
endinterface : ecac_if

`default_nettype wire

// ### ecac_dev.sv
// Data EEPROM access device: address, data and control registers, storage, write timer.
// Assumes the CPU end holds off new accesses while cpu_halt is high.
//
// Functional notes
// - 11-bit address selects one of 2K bytes
// - Software loads address before any access
// - Data register feeds writes, holds read bytes
// - Control bits 7..4 read zero
// - Ready interrupt while enabled and strobe low
// - Strobe within four cycles of arm writes
// - Strobe without arm is ignored
// - Arm clears itself after four cycles
// - Software follows poll, arm, strobe order
// - No write start while flash self-programs
// - Write strobe stays set until write done
// - Write start halts CPU two cycles
// - Read is immediate, halts CPU four cycles
// - No reads or address change during write
// - Write lasts 8448 oscillator cycles
// - Software keeps interrupts off during sequence
`include "ecac_cfg.svh"
`default_nettype none

module ecac_dev #(
  parameter int AW = 11,
  parameter int DEPTH = 2048,
  parameter int WRITE_CLKS = `ECAC_WRITE_CLKS
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  // Core link
  ecac_if.dev LINK,
  // Status
  output logic O_WRITE_ACTIVE
);

  localparam int BW = $clog2(WRITE_CLKS + 1);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [AW-1:0] addr;
    logic [7:0] data;
    logic rie;
    logic arm;
    logic [2:0] arm_cnt;
    logic wstb;
    logic rstb;
    logic [BW-1:0] busy_cnt;
    logic [2:0] halt_cnt;
    logic [7:0] rdata;
  } ecac_dev_state_t;

  ecac_dev_state_t s_r;
  ecac_dev_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Register read decode, shared by the read port
  function automatic logic [7:0] ecac_io_read(input ecac_dev_state_t s, input logic [5:0] a);
    logic [15:0] wide;
    wide = 16'h0000;
    wide[AW-1:0] = s.addr;
    unique case (a)
      `ECAC_IO_CONTROL: ecac_io_read = {4'h0, s.rie, s.arm, s.wstb, s.rstb};
      `ECAC_IO_DATA: ecac_io_read = s.data;
      `ECAC_IO_ADDR_LO: ecac_io_read = wide[7:0];
      `ECAC_IO_ADDR_HI: ecac_io_read = wide[15:8];
      default: ecac_io_read = 8'h00;
    endcase
  endfunction : ecac_io_read

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    logic [15:0] wide_addr;
    logic [7:0] w;
    logic ctl_wr;
    wide_addr = 16'h0000;
    wide_addr[AW-1:0] = s_r.addr;
    w = LINK.io_wdata;
    ctl_wr = LINK.io_we && (LINK.io_addr == `ECAC_IO_CONTROL);
    s_nxt = s_r;

    // Halt countdown; the core stalls while it is non-zero
    if (s_r.halt_cnt != 3'h0)
    begin
      s_nxt.halt_cnt = s_r.halt_cnt - 3'h1;
    end

    // Read strobe lasts one cycle only
    s_nxt.rstb = 1'b0;

    // Arm window countdown, hardware drops the arm when it expires
    if (s_r.arm)
    begin
      s_nxt.arm_cnt = s_r.arm_cnt - 3'h1;
      if (s_r.arm_cnt == 3'h1)
      begin
        s_nxt.arm = 1'b0;
      end
    end

    // Write timer; storage was updated at start, so only the strobe waits
    if (s_r.wstb)
    begin
      if (s_r.busy_cnt == '0)
      begin
        s_nxt.wstb = 1'b0;
      end
      else
      begin
        s_nxt.busy_cnt = s_r.busy_cnt - BW'(1);
      end
    end

    // Data and address writes; the address is frozen during a write
    if (LINK.io_we && LINK.io_addr == `ECAC_IO_DATA)
    begin
      s_nxt.data = w;
    end
    if (LINK.io_we && LINK.io_addr == `ECAC_IO_ADDR_LO && !s_r.wstb)
    begin
      wide_addr[7:0] = w;
      s_nxt.addr = wide_addr[AW-1:0];
    end
    if (LINK.io_we && LINK.io_addr == `ECAC_IO_ADDR_HI && !s_r.wstb)
    begin
      wide_addr[15:8] = w;
      s_nxt.addr = wide_addr[AW-1:0];
    end

    // Control register write
    if (ctl_wr)
    begin
      s_nxt.rie = w[`ECAC_CTL_RIE];
      if (w[`ECAC_CTL_ARM] && !w[`ECAC_CTL_WSTB])
      begin
        s_nxt.arm = 1'b1;
        s_nxt.arm_cnt = `ECAC_ARM_WINDOW;
      end
      else if (!w[`ECAC_CTL_ARM])
      begin
        s_nxt.arm = 1'b0;
      end
      // Strobe counts only while a previous arm is still live
      if (w[`ECAC_CTL_WSTB] && s_r.arm && !s_r.wstb && !LINK.self_program_busy)
      begin
        s_nxt.mem[s_r.addr] = s_r.data;
        s_nxt.wstb = 1'b1;
        s_nxt.arm = 1'b0;
        s_nxt.busy_cnt = BW'(WRITE_CLKS - 1);
        s_nxt.halt_cnt = `ECAC_WRITE_HALT;
      end
      // Reads are refused while a write runs
      if (w[`ECAC_CTL_RSTB] && !s_r.wstb)
      begin
        s_nxt.data = s_r.mem[s_r.addr];
        s_nxt.rstb = 1'b1;
        s_nxt.halt_cnt = `ECAC_READ_HALT;
      end
    end

    // Registered read port, answer one cycle after the request
    if (LINK.io_re)
    begin
      s_nxt.rdata = ecac_io_read(s_r, LINK.io_addr);
    end

    // Contents survive reset, everything else restarts at zero
    if (!I_RST_N)
    begin
      s_nxt = '0;
      s_nxt.mem = s_r.mem;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge I_CORE_CLK)
  begin
    s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign LINK.io_rdata = s_r.rdata;
  assign LINK.cpu_halt = (s_r.halt_cnt != 3'h0);
  assign LINK.ready_irq = s_r.rie && LINK.global_irq_en && !s_r.wstb;
  assign O_WRITE_ACTIVE = s_r.wstb;

endmodule : ecac_dev

`default_nettype wire

// ### ecac_chk.sv
// Checker for the core I/O link between the CPU end and the EEPROM access device.
// Assumes one core clock; the testbench wires the link signals in by name.
`include "ecac_cfg.svh"
`default_nettype none

module ecac_chk #(
  parameter int WRITE_CLKS = `ECAC_WRITE_CLKS
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  // Link
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_we,
  input wire logic io_re,
  input wire logic [7:0] io_rdata,
  input wire logic cpu_halt,
  input wire logic ready_irq,
  input wire logic global_irq_en,
  input wire logic self_program_busy,
  input wire logic O_WRITE_ACTIVE
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RST_N);

  logic wr_ctl;
  logic strobe_ok;
  logic [2:0] arm_cnt;
  logic rie_q;
  logic [31:0] wa_len;

  // Accepted strobe needs a live arm; a busy device or flash refuses it
  assign wr_ctl = io_we && io_addr == `ECAC_IO_CONTROL;
  assign strobe_ok = wr_ctl && io_wdata[1] && arm_cnt != 3'h0 && !O_WRITE_ACTIVE && !self_program_busy;

  // Shadow of the arm window, ready enable and write length
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      arm_cnt <= 3'h0;
      rie_q <= 1'b0;
      wa_len <= 32'h0;
    end
    else
    begin
      if (wr_ctl)
      begin
        arm_cnt <= (io_wdata[2] && !io_wdata[1]) ? 3'h4 : 3'h0;
        rie_q <= io_wdata[3];
      end
      else if (arm_cnt != 3'h0)
        arm_cnt <= arm_cnt - 3'h1;
      wa_len <= O_WRITE_ACTIVE ? wa_len + 32'h1 : 32'h0;
    end
  end

  ////////////////////////////////////////
  sequence s_halt2;
    cpu_halt ##1 cpu_halt ##1 !cpu_halt;
  endsequence
  sequence s_halt4;
    cpu_halt [*4] ##1 !cpu_halt;
  endsequence

  property p_ctl_reserved;
    io_re && io_addr == `ECAC_IO_CONTROL |=> io_rdata[7:4] == 4'h0;
  endproperty
  a_ctl_reserved: assert property (p_ctl_reserved) else $error("reserved control bits not zero");
  property p_ready_irq;
    ready_irq == (rie_q && global_irq_en && !O_WRITE_ACTIVE);
  endproperty
  a_ready_irq: assert property (p_ready_irq) else $error("ready interrupt level wrong");
  property p_arm_start;
    strobe_ok |=> O_WRITE_ACTIVE;
  endproperty
  a_arm_start: assert property (p_arm_start) else $error("armed strobe did not start a write");
  property p_wstb_readback;
    io_re && io_addr == `ECAC_IO_CONTROL |=> io_rdata[1] == $past(O_WRITE_ACTIVE);
  endproperty
  a_wstb_readback: assert property (p_wstb_readback) else $error("write strobe bit differs from write state");
  property p_write_halt;
    $rose(O_WRITE_ACTIVE) |-> s_halt2;
  endproperty
  a_write_halt: assert property (p_write_halt) else $error("write halt not two cycles");
  property p_read_halt;
    wr_ctl && io_wdata[1:0] == 2'h1 && !O_WRITE_ACTIVE |=> s_halt4;
  endproperty
  a_read_halt: assert property (p_read_halt) else $error("read halt not four cycles");
  property p_write_len;
    $fell(O_WRITE_ACTIVE) |-> wa_len == 32'(WRITE_CLKS);
  endproperty
  a_write_len: assert property (p_write_len) else $error("write time wrong");
  property p_spm_block;
    $rose(O_WRITE_ACTIVE) |-> !$past(self_program_busy);
  endproperty
  a_spm_block: assert property (p_spm_block) else $error("write began during flash programming");
endmodule : ecac_chk

`default_nettype wire

// ### testbench.sv
// Testbench: APB drives the CPU end into one device; a raw driver works a second device.
// Assumes both ends share the core clock; the write time is shortened to WCLK cycles.
`include "ecac_cfg.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WCLK = 20;
  localparam logic [5:0] CTL = `ECAC_IO_CONTROL;
  localparam logic [5:0] DAT = `ECAC_IO_DATA;
  localparam logic [5:0] ALO = `ECAC_IO_ADDR_LO;
  localparam logic [5:0] AHI = `ECAC_IO_ADDR_HI;
  logic core_clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wa_a;
  logic wa_b;
  logic [31:0] q;
  logic e;
  logic [7:0] b;
  logic [10:0] addrs [3];
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  ecac_if i_link();
  ecac_if i_link_b();

  ////////////////////////////////////////
  // Host and device joined; a second device under direct drive
  ecac_dev #(.WRITE_CLKS(WCLK)) i_ecac_dev (.I_CORE_CLK(core_clk), .I_RST_N(rst_n), .LINK(i_link.dev),
    .O_WRITE_ACTIVE(wa_a));
  ecac_host i_ecac_host (.I_CORE_CLK(core_clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .LINK(i_link.cpu));
  ecac_dev #(.WRITE_CLKS(WCLK)) i_ecac_dev_b (.I_CORE_CLK(core_clk), .I_RST_N(rst_n), .LINK(i_link_b.dev),
    .O_WRITE_ACTIVE(wa_b));
  ecac_chk #(.WRITE_CLKS(WCLK)) i_ecac_chk (.I_CORE_CLK(core_clk), .I_RST_N(rst_n),
    .io_addr(i_link.io_addr), .io_wdata(i_link.io_wdata), .io_we(i_link.io_we), .io_re(i_link.io_re),
    .io_rdata(i_link.io_rdata), .cpu_halt(i_link.cpu_halt), .ready_irq(i_link.ready_irq),
    .global_irq_en(i_link.global_irq_en), .self_program_busy(i_link.self_program_busy),
    .O_WRITE_ACTIVE(wa_a));

  ////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  // APB transfer; request held until the edge that sees pready high, answer taken at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic aw(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : aw

  task automatic ar(input logic [11:0] a, output logic [31:0] rd);
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
  endtask : ar

  task automatic idle();
    logic [31:0] s;
    do ar(`ECAC_APB_STATUS, s); while (s[0] !== 1'b0);
  endtask : idle

  task automatic hwr(input logic [10:0] a, input logic [7:0] d);
    aw(`ECAC_APB_ADDR, {21'h0, a});
    aw(`ECAC_APB_WDATA, {24'h0, d});
    aw(`ECAC_APB_CMD, 32'h2);
    idle();
  endtask : hwr

  task automatic hrd(input logic [10:0] a, output logic [31:0] rd);
    aw(`ECAC_APB_ADDR, {21'h0, a});
    aw(`ECAC_APB_CMD, 32'h1);
    idle();
    ar(`ECAC_APB_RDATA, rd);
  endtask : hrd

  // Raw link cycle on the second device: op is {write, read}
  task automatic io(input logic [1:0] op, input logic [5:0] a, input logic [7:0] d);
    i_link_b.io_we <= op[1];
    i_link_b.io_re <= op[0];
    i_link_b.io_addr <= a;
    i_link_b.io_wdata <= d;
    @(posedge core_clk);
  endtask : io

  task automatic iord(input logic [5:0] a, output logic [7:0] rd);
    io(2'h1, a, 8'h0);
    io(2'h0, a, 8'h0);
    rd = i_link_b.io_rdata;
  endtask : iord

  ////////////////////////////////////////
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {i_link_b.io_we, i_link_b.io_re, i_link_b.io_addr, i_link_b.io_wdata} = '0;
    {i_link_b.global_irq_en, i_link_b.self_program_busy} = 2'h2;
    addrs = '{11'h000, 11'h7ff, 11'h0ff};
    rst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    // Host side: back-to-back writes at both address extremes and at 0ff, then read back
    aw(`ECAC_APB_CONFIG, 32'h5);
    for (int i = 0; i < 3; i++)
      hwr(addrs[i], addrs[i][10:3] ^ 8'h3c);
    for (int i = 0; i < 3; i++)
    begin
      hrd(addrs[i], q);
      chk(q, {24'h0, addrs[i][10:3] ^ 8'h3c});
    end
    ar(`ECAC_APB_STATUS, q);
    chk(q[1], 1'b1);
    hwr(11'h0ff, 8'h69);
    @(negedge core_clk);
    chk({wa_a, i_link.ready_irq}, 2'h2);
    @(posedge core_clk);
    // Flash programming holds off the write until it ends
    aw(`ECAC_APB_CONFIG, 32'h3);
    aw(`ECAC_APB_ADDR, 32'h0);
    aw(`ECAC_APB_WDATA, 32'h55);
    aw(`ECAC_APB_CMD, 32'h2);
    repeat (40) @(posedge core_clk);
    chk(wa_a, 1'b0);
    aw(`ECAC_APB_CONFIG, 32'h1);
    idle();
    hrd(11'h000, q);
    chk(q, 32'h55);
    ar(`ECAC_APB_STATUS, q);
    chk(q[1], 1'b0);
    apb(1'b0, 12'h018, 32'h0, q, e);
    chk(e, 1'b1);
    // Second device: reserved bits, arm window edges, refusals during a write
    iord(CTL, b);
    chk(b, 8'h00);
    io(2'h2, CTL, 8'hf8);
    iord(CTL, b);
    chk(b, 8'h08);
    chk(i_link_b.ready_irq, 1'b1);
    io(2'h2, ALO, 8'h23);
    io(2'h2, AHI, 8'h01);
    io(2'h2, DAT, 8'h5a);
    io(2'h2, CTL, 8'h04);
    repeat (3) io(2'h0, CTL, 8'h00);
    io(2'h1, CTL, 8'h00);
    io(2'h2, CTL, 8'h02);
    chk(i_link_b.io_rdata, 8'h04);
    repeat (3) io(2'h0, CTL, 8'h00);
    chk(wa_b, 1'b0);
    i_link_b.self_program_busy <= 1'b1;
    io(2'h2, CTL, 8'h04);
    io(2'h2, CTL, 8'h02);
    repeat (3) io(2'h0, CTL, 8'h00);
    chk(wa_b, 1'b0);
    i_link_b.self_program_busy <= 1'b0;
    io(2'h2, CTL, 8'h04);
    repeat (3) io(2'h0, CTL, 8'h00);
    io(2'h2, CTL, 8'h02);
    repeat (2) io(2'h0, CTL, 8'h00);
    chk(wa_b, 1'b1);
    iord(CTL, b);
    chk(b, 8'h02);
    io(2'h2, ALO, 8'h77);
    io(2'h2, DAT, 8'h11);
    io(2'h2, CTL, 8'h01);
    repeat (4) io(2'h0, CTL, 8'h00);
    iord(DAT, b);
    chk(b, 8'h11);
    n = 0;
    do
    begin
      iord(CTL, b);
      n++;
    end while (b[1] !== 1'b0 && n < 40);
    chk(b, 8'h00);
    io(2'h2, CTL, 8'h01);
    repeat (4) io(2'h0, CTL, 8'h00);
    iord(CTL, b);
    chk(b, 8'h00);
    iord(DAT, b);
    chk(b, 8'h5a);
    results();
  end
endmodule : testbench

`default_nettype wire
